// *** verilog/rif_pkg.sv ***
// constants for the remote ir front-end select block: register indexes,
// field positions, reset values, carrier codes and timing counts.
// assumes a single 20 mhz clock; used by rif_top through rif_pkg::name.
package rif_pkg;

	// clock rate
	localparam int CLK_HZ = 20_000_000;

	// register indexes; byte address is four times the index
	localparam logic [2:0] IDX_RX_CTRL = 3'h0;
	localparam logic [2:0] IDX_TX_CTRL = 3'h1;
	localparam logic [2:0] IDX_CFG = 3'h2;
	localparam logic [2:0] IDX_SET = 3'h3;
	localparam logic [2:0] IDX_SEL_SIR = 3'h4;
	localparam logic [2:0] IDX_SEL_FAST = 3'h5;
	localparam logic [2:0] IDX_SEL_REM = 3'h6;
	localparam logic [2:0] IDX_FE_CTRL = 3'h7;

	// set number that maps this register set into the window
	localparam logic [2:0] SET_REMOTE = 3'h7;

	// reset values and fixed read value
	localparam logic [7:0] RST_TX_CTRL = 8'h69;
	localparam logic [7:0] RST_RX_CTRL = 8'h29;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_SET = 8'hf4;
	localparam logic [7:0] SET_READ_VAL = 8'hf4;
	localparam logic [7:0] RST_SEL = 8'h00;
	localparam logic [7:0] RST_FE = 8'h00;

	// writable bit masks; reserved bits are held at zero
	localparam logic [7:0] MASK_CFG = 8'hef;
	localparam logic [7:0] MASK_SEL = 8'h77;
	localparam logic [7:0] MASK_FE = 8'hf8;

	// config register fields
	localparam int CFG_PNC = 7;
	localparam int CFG_OVS = 6;
	localparam int CFG_RXBAND = 5;
	localparam int CFG_TXBAND = 3;
	localparam int CFG_BYPASS = 2;
	localparam int CFG_MOD_LSB = 0;

	// front-end select register fields
	localparam int SEL_MSP = 7;
	localparam int SEL_HI_LSB = 4;
	localparam int SEL_LO_LSB = 0;

	// front-end control register fields
	localparam int FE_AUTO = 7;
	localparam int FE_RXPATH = 6;
	localparam int FE_PINDIR = 5;
	localparam int FE_RX_INVERT = 4;
	localparam int FE_TX_INVERT = 3;

	// transmit control fields
	localparam int TX_FREQ_LSB = 0;
	localparam int TX_PW_LSB = 5;

	// transmit carrier codes, low band then high band
	localparam logic [4:0] FCODE_30K = 5'h03;
	localparam logic [4:0] FCODE_31K = 5'h04;
	localparam logic [4:0] FCODE_56K = 5'h1d;
	localparam logic [4:0] FCODE_400K = 5'h03;
	localparam logic [4:0] FCODE_450K = 5'h08;
	localparam logic [4:0] FCODE_480K = 5'h0b;

	// carrier frequencies in hz and half periods in clock cycles
	localparam int FREQ_30K = 30_000;
	localparam int FREQ_31K = 31_000;
	localparam int FREQ_56K = 56_000;
	localparam int FREQ_400K = 400_000;
	localparam int FREQ_450K = 450_000;
	localparam int FREQ_480K = 480_000;
	localparam logic [9:0] HALF_30K = 10'(CLK_HZ / (2 * FREQ_30K));
	localparam logic [9:0] HALF_31K = 10'(CLK_HZ / (2 * FREQ_31K));
	localparam logic [9:0] HALF_56K = 10'(CLK_HZ / (2 * FREQ_56K));
	localparam logic [9:0] HALF_400K = 10'(CLK_HZ / (2 * FREQ_400K));
	localparam logic [9:0] HALF_450K = 10'(CLK_HZ / (2 * FREQ_450K));
	localparam logic [9:0] HALF_480K = 10'(CLK_HZ / (2 * FREQ_480K));

	// modulation codes and burst lengths
	localparam logic [1:0] MOD_CONT = 2'h0;
	localparam logic [1:0] MOD_8 = 2'h1;
	localparam logic [1:0] MOD_6 = 2'h2;
	localparam logic [3:0] PULSES_8 = 4'h8;
	localparam logic [3:0] PULSES_6 = 4'h6;

	// advanced ir mode codes as delivered by the mode register
	localparam logic [2:0] MODE_SIR = 3'h0;
	localparam logic [2:0] MODE_ASK = 3'h1;
	localparam logic [2:0] MODE_MIR = 3'h2;
	localparam logic [2:0] MODE_FIR = 3'h3;
	localparam logic [2:0] MODE_REMOTE = 3'h4;

	// mode select pulse length, rounded up to whole cycles
	localparam int MSP_TIME_NS = 64_000;
	localparam logic [10:0] MSP_CYCLES =
		11'((MSP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

	// receive energy hold time per band, longer than one carrier period
	localparam int RX_HOLD_LOW_NS = 40_000;
	localparam int RX_HOLD_HIGH_NS = 3_000;
	localparam logic [10:0] RX_HOLD_LOW =
		11'((RX_HOLD_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	localparam logic [10:0] RX_HOLD_HIGH =
		11'((RX_HOLD_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

	// transmit burst states
	typedef enum logic [2:0] {
		TXS_IDLE = 3'b001,
		TXS_BURST = 3'b010,
		TXS_QUIET = 3'b100
	} rif_txs_t;

endpackage

// *** verilog/rif_top.sv ***
// remote ir configuration registers and ir front-end control.
// assumes a classic wishbone master on clk_i, a serial core on the same
// clock giving tx data and bit starts, and asynchronous ir pins.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns

// Summary of operation
// - low band codes 00011, 00100, 11101 give 30, 31, 56 khz carrier.
// - high band codes 00011, 01000, 01011 give 400, 450, 480 khz.
// - config bit 7 switches the remote path to pulse-number coding.
// - pulse-number coding: bit 0 is a high pulse, bit 1 no energy.
// - sampling bit 0 samples once per baud period, 1 oversamples.
// - receive band bit picks 30-56 khz when 0, 400-480 khz when 1.
// - transmit band bit picks 30-56 khz when 0, 400-480 khz when 1.
// - demodulation bit 0 uses the receive decoder, 1 bypasses it.
// - modulation 00 continuous, 01 eight pulses, 10 six pulses per zero.
// - set register reads f4, a write selects the mapped register set.
// - mode-select-pulse bit sends one 64 us pulse on transmit output.
// - auto format in sir mode drives sir select bits to outputs.
// - auto format in ask mode drives ask select bits to outputs.
// - auto format drives fir bits in fir mode, mir bits in mir mode.
// - auto format remote mode drives slow or fast remote bits by transmit band.
// - writing 1 to auto format enables driving the select outputs.
// - shared pin is fast receive input when 0, select output when 1.
// - receive input chosen by module select, aux bit or current speed.
// - high speed means mir or fir; aux receive bit comes from set 5.
// - receive-invert bit inverts the incoming ir signal first.
// - transmit-invert bit inverts transmit output; low bits reserved.
// - carrier code sits in tx control bits 4-0, reset value 69h.
module rif_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [2:0] advanced_ir_mode_i,
	input wire logic aux_rx_i,
	input wire logic tx_data_i,
	input wire logic tx_bit_start_i,
	input wire logic ir_receive_in_i,
	input wire logic shared_pin_i,
	output logic shared_pin_o,
	output logic shared_pin_oe_n_o,
	output logic ir_transmit_out_o,
	output logic [2:0] frontend_select_outputs_o,
	output logic rx_data_o,
	output logic rx_oversample_mode_o,
	output logic rx_decoder_bypass_o,
	output logic rx_carrier_band_o,
	output logic [2:0] tx_pulse_width_code_o,
	output logic [2:0] active_set_o
);

	// register state
	logic [7:0] rx_ctrl_q, rx_ctrl_d;
	logic [7:0] remote_tx_control_q, remote_tx_control_d;
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] set_q, set_d;
	logic [7:0] sel_sir_q, sel_sir_d;
	logic [7:0] sel_fast_q, sel_fast_d;
	logic [7:0] sel_rem_q, sel_rem_d;
	logic [7:0] fe_q, fe_d;
	logic ack_q, ack_d;
	logic [7:0] rdata_q, rdata_d;
	logic [10:0] msp_cnt_q, msp_cnt_d;
	logic req, wr, in_set;
	logic [2:0] ridx;

	// field views
	logic pulse_number_coding_en, rx_oversample_mode, rx_carrier_band;
	logic tx_carrier_band, rx_decoder_bypass;
	logic [1:0] tx_modulation_code;
	logic [4:0] tx_carrier_freq_code;
	logic auto_frontend_format, rx_path_select, shared_pin_direction;
	logic rx_invert, tx_invert, frontend_mode_pulse;

	assign req = cyc_i & stb_i;
	assign ridx = adr_i[4:2];
	assign in_set = (set_q[2:0] == rif_pkg::SET_REMOTE);
	// write lands on the edge where the master sees ack
	assign wr = req & we_i & ack_q & sel_i[0];

	assign pulse_number_coding_en = cfg_q[rif_pkg::CFG_PNC];
	assign rx_oversample_mode = cfg_q[rif_pkg::CFG_OVS];
	assign rx_carrier_band = cfg_q[rif_pkg::CFG_RXBAND];
	assign tx_carrier_band = cfg_q[rif_pkg::CFG_TXBAND];
	assign rx_decoder_bypass = cfg_q[rif_pkg::CFG_BYPASS];
	assign tx_modulation_code = cfg_q[rif_pkg::CFG_MOD_LSB +: 2];
	assign tx_carrier_freq_code =
		remote_tx_control_q[rif_pkg::TX_FREQ_LSB +: 5];
	assign auto_frontend_format = fe_q[rif_pkg::FE_AUTO];
	assign rx_path_select = fe_q[rif_pkg::FE_RXPATH];
	assign shared_pin_direction = fe_q[rif_pkg::FE_PINDIR];
	assign rx_invert = fe_q[rif_pkg::FE_RX_INVERT];
	assign tx_invert = fe_q[rif_pkg::FE_TX_INVERT];
	assign frontend_mode_pulse = (msp_cnt_q != 11'h000);

	// bus slave: one wait state, ack dropped the cycle after it is given
	always_comb begin
		ack_d = req & ~ack_q;
		rdata_d = rdata_q;
		rx_ctrl_d = rx_ctrl_q;
		remote_tx_control_d = remote_tx_control_q;
		cfg_d = cfg_q;
		set_d = set_q;
		sel_sir_d = sel_sir_q;
		sel_fast_d = sel_fast_q;
		sel_rem_d = sel_rem_q;
		fe_d = fe_q;
		msp_cnt_d = frontend_mode_pulse ? msp_cnt_q - 11'h001 : msp_cnt_q;
		if (req & ~ack_q) begin
			if (ridx == rif_pkg::IDX_SET) begin
				rdata_d = rif_pkg::SET_READ_VAL;
			end else if (!in_set) begin
				rdata_d = 8'h00;
			end else if (ridx == rif_pkg::IDX_RX_CTRL) begin
				rdata_d = rx_ctrl_q;
			end else if (ridx == rif_pkg::IDX_TX_CTRL) begin
				rdata_d = remote_tx_control_q;
			end else if (ridx == rif_pkg::IDX_CFG) begin
				rdata_d = cfg_q;
			end else if (ridx == rif_pkg::IDX_SEL_SIR) begin
				rdata_d = {frontend_mode_pulse, sel_sir_q[6:0]};
			end else if (ridx == rif_pkg::IDX_SEL_FAST) begin
				rdata_d = sel_fast_q;
			end else if (ridx == rif_pkg::IDX_SEL_REM) begin
				rdata_d = sel_rem_q;
			end else begin
				rdata_d = fe_q;
			end
		end
		if (wr) begin
			if (ridx == rif_pkg::IDX_SET) begin
				set_d = dat_i[7:0];
			end else if (!in_set) begin
				set_d = set_q;
			end else if (ridx == rif_pkg::IDX_RX_CTRL) begin
				rx_ctrl_d = dat_i[7:0];
			end else if (ridx == rif_pkg::IDX_TX_CTRL) begin
				remote_tx_control_d = dat_i[7:0];
			end else if (ridx == rif_pkg::IDX_CFG) begin
				cfg_d = dat_i[7:0] & rif_pkg::MASK_CFG;
			end else if (ridx == rif_pkg::IDX_SEL_SIR) begin
				sel_sir_d = dat_i[7:0] & rif_pkg::MASK_SEL;
				// a fresh write of 1 restarts the pulse
				if (dat_i[rif_pkg::SEL_MSP]) begin
					msp_cnt_d = rif_pkg::MSP_CYCLES;
				end
			end else if (ridx == rif_pkg::IDX_SEL_FAST) begin
				sel_fast_d = dat_i[7:0] & rif_pkg::MASK_SEL;
			end else if (ridx == rif_pkg::IDX_SEL_REM) begin
				sel_rem_d = dat_i[7:0] & rif_pkg::MASK_SEL;
			end else begin
				fe_d = dat_i[7:0] & rif_pkg::MASK_FE;
			end
		end
	end

	// register file flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
			rx_ctrl_q <= rif_pkg::RST_RX_CTRL;
			remote_tx_control_q <= rif_pkg::RST_TX_CTRL;
			cfg_q <= rif_pkg::RST_CFG;
			set_q <= rif_pkg::RST_SET;
			sel_sir_q <= rif_pkg::RST_SEL;
			sel_fast_q <= rif_pkg::RST_SEL;
			sel_rem_q <= rif_pkg::RST_SEL;
			fe_q <= rif_pkg::RST_FE;
			msp_cnt_q <= 11'h000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			rx_ctrl_q <= rx_ctrl_d;
			remote_tx_control_q <= remote_tx_control_d;
			cfg_q <= cfg_d;
			set_q <= set_d;
			sel_sir_q <= sel_sir_d;
			sel_fast_q <= sel_fast_d;
			sel_rem_q <= sel_rem_d;
			fe_q <= fe_d;
			msp_cnt_q <= msp_cnt_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = {24'h000000, rdata_q};

	// carrier half period from band and code; reserved codes stop it
	logic [9:0] half_cnt;
	always_comb begin
		half_cnt = 10'h000;
		if (!tx_carrier_band) begin
			case (tx_carrier_freq_code)
				rif_pkg::FCODE_30K: half_cnt = rif_pkg::HALF_30K;
				rif_pkg::FCODE_31K: half_cnt = rif_pkg::HALF_31K;
				rif_pkg::FCODE_56K: half_cnt = rif_pkg::HALF_56K;
				default: half_cnt = 10'h000;
			endcase
		end else begin
			case (tx_carrier_freq_code)
				rif_pkg::FCODE_400K: half_cnt = rif_pkg::HALF_400K;
				rif_pkg::FCODE_450K: half_cnt = rif_pkg::HALF_450K;
				rif_pkg::FCODE_480K: half_cnt = rif_pkg::HALF_480K;
				default: half_cnt = 10'h000;
			endcase
		end
	end

	// carrier square wave, restarted at each bit so bursts are whole
	logic [9:0] car_cnt_q, car_cnt_d;
	logic car_q, car_d, car_fall;
	always_comb begin
		car_cnt_d = car_cnt_q + 10'h001;
		car_d = car_q;
		car_fall = 1'b0;
		if (half_cnt == 10'h000 || tx_bit_start_i) begin
			car_cnt_d = 10'h000;
			car_d = 1'b0;
		end else if (car_cnt_q >= half_cnt - 10'h001) begin
			car_cnt_d = 10'h000;
			car_d = ~car_q;
			car_fall = car_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			car_cnt_q <= 10'h000;
			car_q <= 1'b0;
		end else begin
			car_cnt_q <= car_cnt_d;
			car_q <= car_d;
		end
	end

	// counted bursts for the pulsed modulation codes
	rif_pkg::rif_txs_t txs_q, txs_d;
	logic [3:0] pulses_q, pulses_d;
	logic [3:0] burst_len;
	assign burst_len = (tx_modulation_code == rif_pkg::MOD_6) ?
		rif_pkg::PULSES_6 : rif_pkg::PULSES_8;
	always_comb begin
		txs_d = txs_q;
		pulses_d = pulses_q;
		case (txs_q)
			rif_pkg::TXS_IDLE: begin
				pulses_d = 4'h0;
			end
			rif_pkg::TXS_BURST: begin
				if (car_fall) begin
					pulses_d = pulses_q + 4'h1;
				end
				if (car_fall && pulses_q == burst_len - 4'h1) begin
					txs_d = rif_pkg::TXS_QUIET;
				end
			end
			rif_pkg::TXS_QUIET: begin
				pulses_d = 4'h0;
			end
			default: begin
				txs_d = rif_pkg::TXS_IDLE;
			end
		endcase
		// each bit start begins a new burst for a zero, silence for a one
		if (tx_bit_start_i) begin
			pulses_d = 4'h0;
			txs_d = tx_data_i ? rif_pkg::TXS_QUIET : rif_pkg::TXS_BURST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txs_q <= rif_pkg::TXS_IDLE;
			pulses_q <= 4'h0;
		end else begin
			txs_q <= txs_d;
			pulses_q <= pulses_d;
		end
	end

	// transmit line: mode pulse overrides, inversion applied last
	logic tx_energy, tx_out_q, tx_out_d;
	always_comb begin
		if (pulse_number_coding_en) begin
			tx_energy = ~tx_data_i;
		end else if (tx_modulation_code == rif_pkg::MOD_CONT) begin
			tx_energy = ~tx_data_i & car_q;
		end else if (tx_modulation_code == rif_pkg::MOD_8 ||
			tx_modulation_code == rif_pkg::MOD_6) begin
			tx_energy = (txs_q == rif_pkg::TXS_BURST) & car_q;
		end else begin
			tx_energy = 1'b0;
		end
		tx_out_d = (frontend_mode_pulse | tx_energy) ^ tx_invert;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_out_q <= 1'b0;
		end else begin
			tx_out_q <= tx_out_d;
		end
	end

	assign ir_transmit_out_o = tx_out_q;

	// front-end select outputs chosen by mode when auto format is on
	logic [2:0] fe_sel_q, fe_sel_d;
	always_comb begin
		fe_sel_d = 3'h0;
		if (auto_frontend_format) begin
			case (advanced_ir_mode_i)
				rif_pkg::MODE_SIR:
					fe_sel_d = sel_sir_q[rif_pkg::SEL_HI_LSB +: 3];
				rif_pkg::MODE_ASK:
					fe_sel_d = sel_sir_q[rif_pkg::SEL_LO_LSB +: 3];
				rif_pkg::MODE_FIR:
					fe_sel_d = sel_fast_q[rif_pkg::SEL_HI_LSB +: 3];
				rif_pkg::MODE_MIR:
					fe_sel_d = sel_fast_q[rif_pkg::SEL_LO_LSB +: 3];
				rif_pkg::MODE_REMOTE:
					fe_sel_d = tx_carrier_band ?
						sel_rem_q[rif_pkg::SEL_LO_LSB +: 3] :
						sel_rem_q[rif_pkg::SEL_HI_LSB +: 3];
				default:
					fe_sel_d = 3'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fe_sel_q <= 3'h0;
		end else begin
			fe_sel_q <= fe_sel_d;
		end
	end

	assign frontend_select_outputs_o = fe_sel_q;
	// shared pin drives bit 0 only while configured as an output
	assign shared_pin_o = fe_sel_q[0];
	assign shared_pin_oe_n_o = ~shared_pin_direction;

	// pin synchronisers; first stage feeds only the second
	logic rx_m_q, rx_s_q, fast_m_q, fast_s_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_m_q <= 1'b0;
			rx_s_q <= 1'b0;
			fast_m_q <= 1'b0;
			fast_s_q <= 1'b0;
		end else begin
			rx_m_q <= ir_receive_in_i;
			rx_s_q <= rx_m_q;
			fast_m_q <= shared_pin_i;
			fast_s_q <= fast_m_q;
		end
	end

	// receive pin choice; reserved cases fall back to the main input
	logic high_speed, pick_fast, rx_line;
	assign high_speed = (advanced_ir_mode_i == rif_pkg::MODE_MIR) ||
		(advanced_ir_mode_i == rif_pkg::MODE_FIR);
	always_comb begin
		pick_fast = rx_path_select ? high_speed : aux_rx_i;
		if (shared_pin_direction) begin
			pick_fast = 1'b0;
		end
		rx_line = (pick_fast ? fast_s_q : rx_s_q) ^ rx_invert;
	end

	// energy detector: holds for over a carrier period after a high
	logic [10:0] hold_q, hold_d;
	logic rx_out_q, rx_out_d;
	always_comb begin
		hold_d = (hold_q != 11'h000) ? hold_q - 11'h001 : 11'h000;
		if (rx_line) begin
			hold_d = rx_carrier_band ? rif_pkg::RX_HOLD_HIGH :
				rif_pkg::RX_HOLD_LOW;
		end
		// energy means a zero bit, the line idles as a one
		if (rx_decoder_bypass) begin
			rx_out_d = ~rx_line;
		end else begin
			rx_out_d = ~(rx_line | (hold_q != 11'h000));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_q <= 11'h000;
			rx_out_q <= 1'b1;
		end else begin
			hold_q <= hold_d;
			rx_out_q <= rx_out_d;
		end
	end

	assign rx_data_o = rx_out_q;
	assign rx_oversample_mode_o = rx_oversample_mode;
	assign rx_decoder_bypass_o = rx_decoder_bypass;
	assign rx_carrier_band_o = rx_carrier_band;
	assign tx_pulse_width_code_o = remote_tx_control_q[rif_pkg::TX_PW_LSB +: 3];
	assign active_set_o = set_q[2:0];

endmodule

// *** sim/rif_top_monitor.sv ***
// assertions on the ports of the remote ir front-end block.
// assumes one clock, synchronous active-high reset, classic wishbone.
`timescale 1ns/1ns
module rif_top_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic shared_pin_o,
	input wire logic shared_pin_oe_n_o,
	input wire logic ir_transmit_out_o,
	input wire logic [2:0] frontend_select_outputs_o,
	input wire logic rx_oversample_mode_o,
	input wire logic rx_decoder_bypass_o,
	input wire logic rx_carrier_band_o,
	input wire logic [2:0] tx_pulse_width_code_o,
	input wire logic [2:0] active_set_o
);
	logic wr;
	logic [10:0] msp_d;
	logic [10:0] msp_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a write lands at the edge that ends the ack cycle
	assign wr = ack_o && we_i && sel_i[0];
	// mode pulse length counter; a rewrite restarts it
	always_comb begin
		msp_d = (msp_q != 11'h000) ? msp_q - 11'h001 : 11'h000;
		if (wr && adr_i[4:2] == 3'h4 && dat_i[7] && active_set_o == 3'h7) begin
			msp_d = 11'h500;
		end
		if (rst_i) begin
			msp_d = 11'h000;
		end
	end
	always_ff @(posedge clk_i) begin
		msp_q <= msp_d;
	end
	property p_ack_one;
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack held too long");
	property p_ack_wait;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_wait: assert property (p_ack_wait)
		else $error("ack late");
	property p_dat_hi;
		ack_o && !we_i |-> dat_o[31:8] == 24'h000000;
	endproperty
	a_dat_hi: assert property (p_dat_hi)
		else $error("upper read bits set");
	property p_set_read;
		ack_o && !we_i && adr_i[4:2] == 3'h3 |-> dat_o[7:0] == 8'hf4;
	endproperty
	a_set_read: assert property (p_set_read)
		else $error("set register read wrong");
	property p_set_write;
		wr && adr_i[4:2] == 3'h3 |=> active_set_o == $past(dat_i[2:0]);
	endproperty
	a_set_write: assert property (p_set_write)
		else $error("set not selected");
	property p_cfg_write;
		wr && adr_i[4:2] == 3'h2 && active_set_o == 3'h7 |=>
			{rx_oversample_mode_o, rx_carrier_band_o, rx_decoder_bypass_o}
			== {$past(dat_i[6]), $past(dat_i[5]), $past(dat_i[2])};
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("config outputs wrong");
	property p_pw_write;
		wr && adr_i[4:2] == 3'h1 && active_set_o == 3'h7 |=>
			tx_pulse_width_code_o == $past(dat_i[7:5]);
	endproperty
	a_pw_write: assert property (p_pw_write)
		else $error("pulse width code wrong");
	property p_pin_sel;
		!shared_pin_oe_n_o |-> shared_pin_o == frontend_select_outputs_o[0];
	endproperty
	a_pin_sel: assert property (p_pin_sel)
		else $error("shared pin not select bit 0");
	property p_msp_hold;
		msp_q >= 11'h00a && msp_q <= 11'h4f6 |-> $stable(ir_transmit_out_o);
	endproperty
	a_msp_hold: assert property (p_msp_hold)
		else $error("mode pulse broken");
endmodule

// *** sim/rif_xcvr_model.sv ***
// infrared transceiver stand-in: makes receive light, measures transmit.
// assumes the bench sets the light levels; runs on the block's clock.
`timescale 1ns/1ns
module rif_xcvr_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic energy_lo_i,
	input wire logic energy_hi_i,
	input wire logic tx_i,
	input wire logic pin_drv_i,
	input wire logic pin_oe_n_i,
	output logic rx_line_o,
	output logic pin_line_o,
	output logic [15:0] edges_o = 16'h0000,
	output logic [15:0] run_o = 16'h0000
);
	logic [15:0] cnt = 16'h0000;
	logic tx_prev = 1'b0;
	// receive lines idle low, high while light is seen
	assign rx_line_o = energy_lo_i;
	// block output wins when it drives, else the fast receiver
	assign pin_line_o = pin_oe_n_i ? energy_hi_i : pin_drv_i;
	// rising edges and length of the last high run of transmit
	always @(posedge clk_i) begin
		tx_prev <= tx_i;
		cnt <= tx_i ? cnt + 16'h0001 : 16'h0000;
		if (tx_i && !tx_prev) begin
			edges_o <= edges_o + 16'h0001;
		end
		if (!tx_i && tx_prev) begin
			run_o <= cnt;
		end
		if (clr_i) begin
			edges_o <= 16'h0000;
			run_o <= 16'h0000;
		end
	end
endmodule

// *** sim/tb_remote_ir_frontend_select.sv ***
// self-checking bench for the remote ir front-end block.
// assumes rif_top, the transceiver model and the monitor are compiled.
`timescale 1ns/1ns
module tb_remote_ir_frontend_select;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0;
	logic [2:0] advanced_ir_mode_i = 3'h0;
	logic aux_rx_i = 1'b0;
	logic tx_data_i = 1'b1;
	logic tx_bit_start_i = 1'b0;
	logic e_lo = 1'b0;
	logic e_hi = 1'b0;
	logic clr = 1'b0;
	logic ir_receive_in_i, shared_pin_i, shared_pin_o, shared_pin_oe_n_o;
	logic ack_o, ir_transmit_out_o, rx_data_o, rx_oversample_mode_o;
	logic rx_decoder_bypass_o, rx_carrier_band_o;
	logic [31:0] dat_o;
	logic [2:0] frontend_select_outputs_o, tx_pulse_width_code_o;
	logic [2:0] active_set_o;
	logic [15:0] edges, run;
	logic [7:0] rd;
	int n_fail = 0;
	int num_checks = 0;
	always #25 clk_i = ~clk_i;
	rif_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .advanced_ir_mode_i, .aux_rx_i, .tx_data_i,
		.tx_bit_start_i, .ir_receive_in_i, .shared_pin_i, .shared_pin_o,
		.shared_pin_oe_n_o, .ir_transmit_out_o, .frontend_select_outputs_o,
		.rx_data_o, .rx_oversample_mode_o, .rx_decoder_bypass_o,
		.rx_carrier_band_o, .tx_pulse_width_code_o, .active_set_o);
	rif_xcvr_model xcvr (.clk_i, .clr_i(clr), .energy_lo_i(e_lo),
		.energy_hi_i(e_hi), .tx_i(ir_transmit_out_o), .pin_drv_i(shared_pin_o),
		.pin_oe_n_i(shared_pin_oe_n_o), .rx_line_o(ir_receive_in_i),
		.pin_line_o(shared_pin_i), .edges_o(edges), .run_o(run));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle; the answer delay is never assumed
	task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h000000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask
	task automatic bit_start(input logic d);
		@(posedge clk_i);
		tx_data_i <= d;
		tx_bit_start_i <= 1'b1;
		@(posedge clk_i);
		tx_bit_start_i <= 1'b0;
	endtask
	task automatic t_regs();
		chk(active_set_o, 3'h4);
		rdc(3'h1, 8'h00);
		rdc(3'h3, 8'hf4);
		wb(1'b1, 3'h3, 8'h07);
		wt(2);
		chk(active_set_o, 3'h7);
		rdc(3'h3, 8'hf4);
		rdc(3'h1, 8'h69);
		chk(tx_pulse_width_code_o, 3'h3);
		for (int i = 2; i < 8; i++) begin
			if (i != 3) rdc(3'(i), 8'h00);
		end
		wb(1'b1, 3'h2, 8'hff);
		rdc(3'h2, 8'hef);
		chk({rx_oversample_mode_o, rx_carrier_band_o, rx_decoder_bypass_o},
			3'h7);
		wb(1'b1, 3'h2, 8'h00);
		wt(2);
		chk({rx_oversample_mode_o, rx_carrier_band_o, rx_decoder_bypass_o},
			3'h0);
		$display("register test done");
	endtask
	// select outputs per mode, with auto format off and on
	task automatic t_sel();
		logic [2:0] ex[5] = '{3'h5, 3'h3, 3'h2, 3'h6, 3'h4};
		wb(1'b1, 3'h4, 8'h53);
		wb(1'b1, 3'h5, 8'h62);
		wb(1'b1, 3'h6, 8'h41);
		wt(3);
		chk(frontend_select_outputs_o, 3'h0);
		wb(1'b1, 3'h7, 8'h80);
		for (int m = 0; m < 5; m++) begin
			advanced_ir_mode_i <= 3'(m);
			wt(3);
			chk(frontend_select_outputs_o, ex[m]);
		end
		wb(1'b1, 3'h2, 8'h08);
		wt(3);
		chk(frontend_select_outputs_o, 3'h1);
		advanced_ir_mode_i <= 3'h0;
		wb(1'b1, 3'h7, 8'ha0);
		wt(3);
		chk({shared_pin_oe_n_o, shared_pin_o}, 2'b01);
		wb(1'b1, 3'h7, 8'h00);
		wb(1'b1, 3'h2, 8'h00);
		wt(3);
		chk(shared_pin_oe_n_o, 1'b1);
		$display("select test done");
	endtask
	task automatic rx_try(input logic [7:0] c, input logic a,
		input logic [2:0] m, input logic lo, input logic hi, input logic exp);
		wb(1'b1, 3'h7, c);
		aux_rx_i <= a;
		advanced_ir_mode_i <= m;
		e_lo <= lo;
		e_hi <= hi;
		wt(20);
		chk(rx_data_o, exp);
		e_lo <= 1'b0;
		e_hi <= 1'b0;
		wt(900);
	endtask
	// high band hold or bypass must release well before the low band hold
	task automatic rx_fast(input logic [7:0] c);
		wb(1'b1, 3'h2, c);
		e_lo <= 1'b1;
		wt(20);
		chk(rx_data_o, 1'b0);
		e_lo <= 1'b0;
		wt(70);
		chk(rx_data_o, 1'b1);
	endtask
	// receive path choice; single path setups keep module select 0
	task automatic t_rx();
		rx_try(8'h00, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0);
		rx_try(8'h00, 1'b1, 3'h0, 1'b0, 1'b1, 1'b0);
		rx_try(8'h00, 1'b1, 3'h0, 1'b1, 1'b0, 1'b1);
		rx_try(8'h40, 1'b0, 3'h2, 1'b0, 1'b1, 1'b0);
		rx_try(8'h40, 1'b0, 3'h3, 1'b0, 1'b1, 1'b0);
		rx_try(8'h40, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
		rx_try(8'h10, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		wb(1'b1, 3'h7, 8'h00);
		wt(900);
		chk(rx_data_o, 1'b1);
		rx_fast(8'h20);
		rx_fast(8'h04);
		wb(1'b1, 3'h2, 8'h00);
		$display("receive test done");
	endtask
	// carrier codes per band and modulation codes; -1 means continuous
	task automatic t_tx();
		logic [7:0] cf[8] = '{8'h01, 8'h02, 8'h01, 8'h09, 8'h0a, 8'h03,
			8'h09, 8'h08};
		logic [7:0] tc[8] = '{8'h63, 8'h64, 8'h7d, 8'h68, 8'h6b, 8'h63,
			8'h63, 8'h68};
		int fq[8] = '{30000, 31000, 56000, 450000, 480000, 30000, 400000,
			450000};
		int np[8] = '{8, 6, 8, 8, 6, 0, 8, -1};
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 3'h2, cf[i]);
			wb(1'b1, 3'h1, tc[i]);
			clr <= 1'b1;
			bit_start(1'b0);
			clr <= 1'b0;
			wt(6000);
			if (np[i] < 0) chk(32'(edges > 16'd100), 1);
			else chk(edges, 32'(np[i]));
			chk(run, np[i] == 0 ? 0 : 20000000 / (2 * fq[i]));
		end
		bit_start(1'b1);
		$display("transmit test done");
	endtask
	task automatic t_pnc();
		wb(1'b1, 3'h2, 8'h80);
		bit_start(1'b0);
		wt(5);
		chk(ir_transmit_out_o, 1'b1);
		bit_start(1'b1);
		wt(5);
		chk(ir_transmit_out_o, 1'b0);
		wb(1'b1, 3'h7, 8'h08);
		wt(3);
		chk(ir_transmit_out_o, 1'b1);
		wb(1'b1, 3'h7, 8'h00);
		wb(1'b1, 3'h2, 8'h00);
		$display("pulse coding test done");
	endtask
	task automatic t_msp();
		clr <= 1'b1;
		wt(1);
		clr <= 1'b0;
		wb(1'b1, 3'h4, 8'hd3);
		wt(1400);
		chk(run, 32'd1280);
		rdc(3'h4, 8'h53);
		$display("mode pulse test done");
	endtask
	initial begin
		wt(5);
		rst_i <= 1'b0;
		t_regs();
		t_sel();
		t_rx();
		t_tx();
		t_pnc();
		t_msp();
		report_and_stop();
	end
	// watchdog well past the expected length of the whole run
	initial begin
		wt(90000);
		n_fail++;
		report_and_stop();
	end
endmodule
bind rif_top rif_top_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .shared_pin_o, .shared_pin_oe_n_o,
	.ir_transmit_out_o, .frontend_select_outputs_o, .rx_oversample_mode_o,
	.rx_decoder_bypass_o, .rx_carrier_band_o, .tx_pulse_width_code_o,
	.active_set_o);
